// [rtl/mft_defs.svh]
// Offsets, field positions, reset values and behaviour list of the timer.
// Behaviour
// - Capture B edge sets capture_b_flag, sticky.
// - Capture A edge sets capture_a_flag, sticky.
// - capture_irq_enable gates capture flags onto interrupt.
// - Match on active compare_value_b sets compare_b_flag.
// - Match on active compare_value_a sets compare_a_flag.
// - compare_irq_enable gates compare flags onto interrupt.
// - Counter wrap FFFF to 0000 sets wrap_flag.
// - wrap_irq_enable gates wrap flag onto interrupt.
// - Real-time counter wrap sets sticky mode bit 7.
// - capture_edge_select picks rising or falling capture edge.
// - event_clock_edge_select picks counted event clock edge.
// - prescale_select divides clock by two to field.
// - mode_select chooses software, PWM, capture, event mode.
// - Two capture inputs, compare output, event clock input.
// - Counter clears on reset, then counts upward.
// - Outside capture mode, counter alternates compare_value_a and b, restarting at zero.
// - Capture B loads compare_value_b, A loads capture register.
// - Capture mode match on A toggles output, counter runs.
`ifndef MFT_DEFS_SVH
`define MFT_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MFT_OFF_FLAGS   8'h00
`define MFT_OFF_MODE    8'h04
`define MFT_OFF_CMPA    8'h08
`define MFT_OFF_CMPB    8'h0C
`define MFT_OFF_CAPT    8'h10
`define MFT_OFF_COUNT   8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MFT_CPF_B       7
`define MFT_CPF_A       6
`define MFT_CPIE        5
`define MFT_CMF_B       4
`define MFT_CMF_A       3
`define MFT_CMIE        2
`define MFT_WRF         1
`define MFT_WRIE        0
`define MFT_FLAG_MASK   8'hDA
`define MFT_RTC_WRF     7
`define MFT_CAP_EDGE    6
`define MFT_EVT_EDGE    5
`define MFT_PS_HI       4
`define MFT_PS_LO       2
`define MFT_MODE_HI     1
`define MFT_MODE_LO     0
`define MFT_MODE_FLAGS  8'h80

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MFT_RST_FLAGS   8'h00
`define MFT_RST_MODE    8'h00
`define MFT_RST_CMP     16'h0000
`define MFT_RST_COUNT   16'h0000
`define MFT_COUNT_MAX   16'hFFFF

`endif

// [rtl/mft_pkg.sv]
// Types shared by the multi-function timer.
package mft_pkg;

  typedef enum logic [1:0] {
    MFT_MODE_SOFT  = 2'h0,
    MFT_MODE_PWM   = 2'h1,
    MFT_MODE_CAPT  = 2'h2,
    MFT_MODE_EVENT = 2'h3
  } mft_mode_t;

  typedef enum logic {
    MFT_SEL_A = 1'h0,
    MFT_SEL_B = 1'h1
  } mft_sel_t;

endpackage

// [rtl/mft_ctrl.sv]
// Multi-function timer control and status with an APB register slave.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "mft_defs.svh"

module mft_ctrl #(
  parameter int CW = 16,
  parameter int AW = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output      logic [31:0]   prdata,
  output      logic          pready,
  output      logic          pslverr,
  input  wire logic          capture_a_in,
  input  wire logic          capture_b_in,
  input  wire logic          event_clk_in,
  input  wire logic          realtime_counter_wrap,
  output      logic          compare_out,
  output      logic          timer_irq,
  output      mft_pkg::mft_sel_t active_sel
);
  import mft_pkg::*;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [7:0]    flags_enables;
  logic [7:0]    mode_prescale;
  logic [CW-1:0] compare_value_a;
  logic [CW-1:0] compare_value_b;
  logic [CW-1:0] capture_value;
  logic [CW-1:0] count;
  logic [6:0]    presc_cnt;
  logic          cap_a_prev;
  logic          cap_b_prev;
  logic          evt_prev;

  logic [7:0]    next_flags_enables;
  logic [7:0]    next_mode_prescale;
  logic [7:0]    flag_set;
  logic [6:0]    presc_mask;
  logic [31:0]   rd_word;
  logic          rd_hit;
  mft_mode_t     mode;
  logic          wr_acc;
  logic          presc_hit;
  logic          evt_edge;
  logic          tick;
  logic          cap_a_evt;
  logic          cap_b_evt;
  logic          match_a;
  logic          match_b;
  logic          restart;
  logic          wrap_evt;

  // --------------------------------------------------------------------
  // Event detection
  // --------------------------------------------------------------------
  assign mode   = mft_mode_t'(mode_prescale[`MFT_MODE_HI:`MFT_MODE_LO]);
  assign wr_acc = ce && psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_a_prev <= 1'b0;
      cap_b_prev <= 1'b0;
      evt_prev   <= 1'b0;
    end else if (ce) begin
      cap_a_prev <= capture_a_in;
      cap_b_prev <= capture_b_in;
      evt_prev   <= event_clk_in;
    end
  end

  // Both capture pins share one edge polarity.
  always_comb begin
    if (mode_prescale[`MFT_CAP_EDGE]) begin
      cap_a_evt = capture_a_in && !cap_a_prev;
      cap_b_evt = capture_b_in && !cap_b_prev;
    end else begin
      cap_a_evt = !capture_a_in && cap_a_prev;
      cap_b_evt = !capture_b_in && cap_b_prev;
    end
    cap_a_evt = cap_a_evt && ce && (mode == MFT_MODE_CAPT);
    cap_b_evt = cap_b_evt && ce && (mode == MFT_MODE_CAPT);
  end

  assign evt_edge = mode_prescale[`MFT_EVT_EDGE] ?
                    (event_clk_in && !evt_prev) :
                    (!event_clk_in && evt_prev);

  // --------------------------------------------------------------------
  // Prescaler and counter
  // --------------------------------------------------------------------
  // A free-running divider keeps the tick rate exact when the field
  // changes, at the cost of one short first period after the change.
  assign presc_mask = 7'((8'h01 << mode_prescale[`MFT_PS_HI:`MFT_PS_LO]) -
                         8'h01);
  assign presc_hit  = ((presc_cnt & presc_mask) == presc_mask);
  assign tick       = ce && ((mode == MFT_MODE_EVENT) ? evt_edge
                                                      : presc_hit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt <= 7'h00;
    end else if (ce) begin
      presc_cnt <= presc_cnt + 7'h01;
    end
  end

  assign match_a  = tick && (count == compare_value_a) &&
                    ((mode == MFT_MODE_CAPT) || (active_sel == MFT_SEL_A));
  assign match_b  = tick && (count == compare_value_b) &&
                    (mode != MFT_MODE_CAPT) && (active_sel == MFT_SEL_B);
  assign restart  = (match_a || match_b) && (mode != MFT_MODE_CAPT);
  assign wrap_evt = tick && !restart && (count == `MFT_COUNT_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `MFT_RST_COUNT;
    end else if (restart) begin
      count <= `MFT_RST_COUNT;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_sel <= MFT_SEL_A;
    end else if (restart) begin
      case (active_sel)
        MFT_SEL_A: active_sel <= MFT_SEL_B;
        MFT_SEL_B: active_sel <= MFT_SEL_A;
        default:   active_sel <= MFT_SEL_A;
      endcase
    end
  end

  // Software and event modes keep the pin still.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_out <= 1'b0;
    end else if ((mode == MFT_MODE_PWM) && restart) begin
      compare_out <= !compare_out;
    end else if ((mode == MFT_MODE_CAPT) && match_a) begin
      compare_out <= !compare_out;
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_comb begin
    flag_set = 8'h00;
    flag_set[`MFT_CPF_B] = cap_b_evt;
    flag_set[`MFT_CPF_A] = cap_a_evt;
    flag_set[`MFT_CMF_B] = match_b;
    flag_set[`MFT_CMF_A] = match_a;
    flag_set[`MFT_WRF]   = wrap_evt;
  end

  // A written one keeps a flag, a written zero clears it; a set in the
  // same cycle wins over the clear.
  always_comb begin
    next_flags_enables = flags_enables;
    next_mode_prescale = mode_prescale;
    if (wr_acc && (paddr == `MFT_OFF_FLAGS)) begin
      next_flags_enables = (pwdata[7:0] & ~`MFT_FLAG_MASK) |
                           (flags_enables & pwdata[7:0] &
                            `MFT_FLAG_MASK);
    end
    if (wr_acc && (paddr == `MFT_OFF_MODE)) begin
      next_mode_prescale = (pwdata[7:0] & ~`MFT_MODE_FLAGS) |
                           (mode_prescale & pwdata[7:0] &
                            `MFT_MODE_FLAGS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_enables <= `MFT_RST_FLAGS;
      mode_prescale <= `MFT_RST_MODE;
    end else if (ce) begin
      flags_enables <= next_flags_enables | flag_set;
      mode_prescale <= next_mode_prescale |
                       {realtime_counter_wrap, 7'h00};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value_a <= `MFT_RST_CMP;
      compare_value_b <= `MFT_RST_CMP;
      capture_value   <= `MFT_RST_CMP;
    end else begin
      if (wr_acc && (paddr == `MFT_OFF_CMPA)) begin
        compare_value_a <= pwdata[CW-1:0];
      end
      // A capture wins over a software write in the same cycle.
      if (cap_b_evt) begin
        compare_value_b <= count;
      end else if (wr_acc && (paddr == `MFT_OFF_CMPB)) begin
        compare_value_b <= pwdata[CW-1:0];
      end
      if (cap_a_evt) begin
        capture_value <= count;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
    end else if (ce) begin
      timer_irq <= (flags_enables[`MFT_CPIE] &&
                    (flags_enables[`MFT_CPF_A] ||
                     flags_enables[`MFT_CPF_B])) ||
                   (flags_enables[`MFT_CMIE] &&
                    (flags_enables[`MFT_CMF_A] ||
                     flags_enables[`MFT_CMF_B])) ||
                   (flags_enables[`MFT_WRIE] &&
                    flags_enables[`MFT_WRF]);
    end
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr)
      `MFT_OFF_FLAGS: rd_word[7:0]    = flags_enables;
      `MFT_OFF_MODE:  rd_word[7:0]    = mode_prescale;
      `MFT_OFF_CMPA:  rd_word[CW-1:0] = compare_value_a;
      `MFT_OFF_CMPB:  rd_word[CW-1:0] = compare_value_b;
      `MFT_OFF_CAPT:  rd_word[CW-1:0] = capture_value;
      `MFT_OFF_COUNT: rd_word[CW-1:0] = count;
      default:        rd_hit          = 1'b0;
    endcase
  end

  // Read data is taken in the setup cycle, so it is one cycle old by
  // the completing edge; with ce high the answer comes after one wait-free
  // access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_pwm_match;
    ce && restart && (mode == MFT_MODE_PWM);
  endsequence

  sequence seq_restart_toggle;
    (count == 16'h0000) && $changed(compare_out) && $changed(active_sel);
  endsequence

  chk_cap_b_flag: assert property (cap_b_evt |=>
    flags_enables[`MFT_CPF_B] && (compare_value_b == $past(count)))
    else $error("Capture B did not set its flag or load.");

  chk_cap_a_flag: assert property (cap_a_evt |=>
    flags_enables[`MFT_CPF_A] && (capture_value == $past(count)))
    else $error("Capture A did not set its flag or load.");

  chk_cap_irq: assert property (ce && flags_enables[`MFT_CPIE] &&
    flags_enables[`MFT_CPF_A] |=> timer_irq)
    else $error("Enabled capture flag raised no interrupt.");

  chk_cmp_b_flag: assert property (match_b |=>
    flags_enables[`MFT_CMF_B] && (active_sel == MFT_SEL_A))
    else $error("Compare B match not flagged.");

  chk_cmp_a_flag: assert property (ce && tick &&
    (active_sel == MFT_SEL_A) && (count == compare_value_a) |=>
    flags_enables[`MFT_CMF_A])
    else $error("Compare A match not flagged.");

  chk_wrap_flag: assert property (wrap_evt |=>
    flags_enables[`MFT_WRF] && (count == 16'h0000))
    else $error("Counter wrap not flagged.");

  chk_rtc_flag: assert property (ce && realtime_counter_wrap |=>
    mode_prescale[`MFT_RTC_WRF])
    else $error("Real-time wrap not flagged.");

  chk_pwm_restart: assert property (seq_pwm_match |=>
    seq_restart_toggle)
    else $error("PWM match did not restart and toggle.");

  chk_irq_quiet: assert property (ce &&
    ((flags_enables & {1'b0, flags_enables[7:1]} & 8'h25) == 8'h00) &&
    ((flags_enables & {2'b00, flags_enables[7:2]} & 8'h24) == 8'h00) |=>
    !timer_irq)
    else $error("Interrupt without an enabled flag.");

  chk_flag_sticky: assert property (ce && flags_enables[`MFT_WRF] &&
    !(wr_acc && (paddr == `MFT_OFF_FLAGS)) |=> flags_enables[`MFT_WRF])
    else $error("Wrap flag dropped without a write.");

  chk_free_run: assert property (match_a &&
    (mode == MFT_MODE_CAPT) && (count != `MFT_COUNT_MAX) |=>
    (count == $past(count) + 16'h0001) && $changed(compare_out))
    else $error("Capture mode match stopped the counter.");

  chk_presc_div: assert property (ce &&
    (mode_prescale[`MFT_MODE_HI:`MFT_MODE_LO] == 2'h0) &&
    (mode_prescale[`MFT_PS_HI:`MFT_PS_LO] == 3'h0) |-> tick)
    else $error("Divide by one did not tick every cycle.");

endmodule

// [bench/mft_pins.sv]
// Partner model that drives the timer's capture, event and wrap pins.
`timescale 1ns/10ps

module mft_pins (
  input  wire logic pclk,
  output      logic capture_a_in,
  output      logic capture_b_in,
  output      logic event_clk_in,
  output      logic realtime_counter_wrap
);
  initial begin
    capture_a_in          = 1'b0;
    capture_b_in          = 1'b0;
    event_clk_in          = 1'b0;
    realtime_counter_wrap = 1'b0;
  end

  // --------------------------------------------------------------------
  // Pin driver
  // --------------------------------------------------------------------
  // Capture and event levels are held three cycles, since closer edges may go unseen; the wrap pin is high for one cycle.
  task automatic pin(input int k, input logic v);
    @(posedge pclk);
    case (k)
      0: capture_a_in <= v;
      1: capture_b_in <= v;
      2: event_clk_in <= v;
      default: realtime_counter_wrap <= v;
    endcase
    if (k == 3) begin
      @(posedge pclk);
      realtime_counter_wrap <= 1'b0;
    end
    repeat (2) @(posedge pclk);
  endtask
endmodule

// [bench/tb_top.sv]
// Self-checking testbench of the multi-function timer control block.
`timescale 1ns/10ps
`include "mft_defs.svh"

module tb_top;
  import mft_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, ce;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q, c0;
  logic        pready, pslverr, err_q, cap_a, cap_b, evt, rtc_w;
  logic        compare_out, timer_irq;
  mft_sel_t    active_sel;
  int          fail_count, n_compared;

  mft_ctrl mft_ctrl_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_a_in(cap_a), .capture_b_in(cap_b),
    .event_clk_in(evt), .realtime_counter_wrap(rtc_w),
    .compare_out(compare_out), .timer_irq(timer_irq),
    .active_sel(active_sel));
  mft_pins mft_pins_inst (.pclk(pclk), .capture_a_in(cap_a),
    .capture_b_in(cap_b), .event_clk_in(evt),
    .realtime_counter_wrap(rtc_w));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic hang();
    fail_count++;
    stop_test();
  endtask

  // An idle cycle precedes each setup so no signal is driven twice.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) hang();
    end while (pready !== 1'b1);
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tog(output int c);
    logic o;
    c = 0;
    o = compare_out;
    do begin
      @(negedge pclk);
      c++;
      if (c > 3000) hang();
    end while (compare_out === o);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_rst();
    apb(1'b0, `MFT_OFF_MODE, 32'h0);
    chk("mode reset", rd_q, 32'h0);
    apb(1'b0, `MFT_OFF_COUNT, 32'h0);
    chk("count reset", rd_q, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", err_q, 32'h1);
    $display("reset test done");
  endtask

  task automatic t_pwm();
    int   c, e;
    logic o0;
    apb(1'b1, `MFT_OFF_CMPA, 32'h5);
    apb(1'b1, `MFT_OFF_CMPB, 32'h3);
    for (int p = 0; p < 8; p++) begin
      apb(1'b1, `MFT_OFF_MODE, {27'h0, p[2:0], 2'h1});
      tog(c);
      tog(c);
      e = (active_sel === MFT_SEL_B) ? 4 : 6;
      tog(c);
      chk("pwm interval", c, e << p);
      chk("active swap", active_sel,
          (e == 4) ? MFT_SEL_A : MFT_SEL_B);
    end
    apb(1'b1, `MFT_OFF_MODE, 32'h0);
    apb(1'b1, `MFT_OFF_FLAGS, 32'h0);
    o0 = compare_out;
    repeat (30) @(negedge pclk);
    chk("irq masked", timer_irq, 32'h0);
    chk("soft pin still", compare_out, o0);
    apb(1'b0, `MFT_OFF_FLAGS, 32'h0);
    chk("match flags", rd_q & 32'h18, 32'h18);
    apb(1'b1, `MFT_OFF_FLAGS, 32'h4);
    repeat (30) @(negedge pclk);
    chk("irq compare", timer_irq, 32'h1);
    $display("pwm test done");
  endtask

  task automatic t_cap();
    int n;
    apb(1'b1, `MFT_OFF_MODE, 32'h42);
    // Let the leftover compare A match pass before the flags are cleared.
    repeat (8) @(posedge pclk);
    apb(1'b1, `MFT_OFF_FLAGS, 32'h20);
    apb(1'b0, `MFT_OFF_COUNT, 32'h0);
    c0 = rd_q;
    mft_pins_inst.pin(1, 1'b1);
    repeat (2) @(negedge pclk);
    chk("irq capture", timer_irq, 32'h1);
    apb(1'b0, `MFT_OFF_FLAGS, 32'h0);
    chk("flag b", rd_q, 32'hA0);
    apb(1'b0, `MFT_OFF_CMPB, 32'h0);
    chk("capture b", rd_q > c0 && rd_q - c0 < 40, 32'h1);
    apb(1'b1, `MFT_OFF_FLAGS, 32'hA0);
    apb(1'b0, `MFT_OFF_FLAGS, 32'h0);
    chk("flag kept", rd_q, 32'hA0);
    apb(1'b1, `MFT_OFF_FLAGS, 32'h20);
    apb(1'b1, `MFT_OFF_MODE, 32'h02);
    mft_pins_inst.pin(0, 1'b1);
    apb(1'b0, `MFT_OFF_FLAGS, 32'h0);
    chk("rise ignored", rd_q, 32'h20);
    apb(1'b0, `MFT_OFF_COUNT, 32'h0);
    c0 = rd_q;
    mft_pins_inst.pin(0, 1'b0);
    apb(1'b0, `MFT_OFF_FLAGS, 32'h0);
    chk("flag a", rd_q, 32'h60);
    apb(1'b0, `MFT_OFF_CAPT, 32'h0);
    chk("capture a", rd_q > c0 && rd_q - c0 < 40, 32'h1);
    apb(1'b1, `MFT_OFF_FLAGS, 32'h0);
    mft_pins_inst.pin(1, 1'b0);
    repeat (2) @(negedge pclk);
    chk("capture masked", timer_irq, 32'h0);
    apb(1'b0, `MFT_OFF_COUNT, 32'h0);
    c0 = rd_q;
    @(posedge pclk);
    ce <= 1'b0;
    repeat (50) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, `MFT_OFF_COUNT, 32'h0);
    chk("ce freeze", rd_q - c0 < 10, 32'h1);
    apb(1'b1, `MFT_OFF_FLAGS, 32'h1);
    n = 0;
    while (timer_irq !== 1'b1) begin
      @(negedge pclk);
      n++;
      if (n > 70000) hang();
    end
    apb(1'b0, `MFT_OFF_FLAGS, 32'h0);
    chk("wrap flag", rd_q & 32'h2, 32'h2);
    $display("capture test done");
  endtask

  task automatic t_evt();
    apb(1'b1, `MFT_OFF_CMPA, 32'hFFFF);
    apb(1'b1, `MFT_OFF_CMPB, 32'hFFFF);
    apb(1'b1, `MFT_OFF_MODE, 32'h23);
    apb(1'b0, `MFT_OFF_COUNT, 32'h0);
    c0 = rd_q;
    for (int i = 0; i < 3; i++) begin
      mft_pins_inst.pin(2, 1'b1);
      mft_pins_inst.pin(2, 1'b0);
    end
    apb(1'b0, `MFT_OFF_COUNT, 32'h0);
    chk("rise events", rd_q, c0 + 3);
    apb(1'b1, `MFT_OFF_MODE, 32'h03);
    mft_pins_inst.pin(2, 1'b1);
    mft_pins_inst.pin(2, 1'b0);
    apb(1'b0, `MFT_OFF_COUNT, 32'h0);
    chk("fall events", rd_q, c0 + 4);
    mft_pins_inst.pin(3, 1'b1);
    apb(1'b0, `MFT_OFF_MODE, 32'h0);
    chk("rtc wrap", rd_q, 32'h83);
    apb(1'b1, `MFT_OFF_MODE, 32'h03);
    apb(1'b0, `MFT_OFF_MODE, 32'h0);
    chk("rtc cleared", rd_q, 32'h03);
    $display("event test done");
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    presetn    = 1'b0;
    ce         = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    fail_count = 0;
    n_compared = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_rst();
    t_pwm();
    t_cap();
    t_evt();
    stop_test();
  end
endmodule
